//--- rtl/bwssp_pkg.sv
package bwssp_pkg;

  // Bus shape: word address A31..A2 and active-low byte enables
  localparam int ADDR_W = 30;
  typedef logic [ADDR_W-1:0] bwssp_addr_t;
  typedef logic [3:0]        bwssp_wait_t;

  // Attributes of one bus cycle as seen at its address strobe
  typedef struct packed {
    logic        mem;    // 1 = memory cycle, 0 = I/O cycle
    logic        wr;     // 1 = write
    bwssp_addr_t addr;
    logic [3:0]  be_n;
  } bwssp_cyc_t;

  // Bus state tracker
  typedef enum logic [1:0] {
    BWSSP_TRK_IDLE,
    BWSSP_TRK_BUSY,
    BWSSP_TRK_PEND
  } bwssp_trk_t;

  // Wait count registers
  localparam int          NUM_WAIT = 6;
  localparam int          NUM_SEL  = 3;
  localparam bwssp_wait_t WAIT_RST = 4'hF;
  localparam logic [1:0]  SEL_NONE = 2'h3;

  // Byte offsets inside the register window
  localparam logic [7:0] OFF_WAIT0 = 8'h72;
  localparam logic [7:0] OFF_RELOC = 8'h7F;
  localparam logic [7:0] OFF_LIMIT = 8'hDB;

  // Relocation register layout and reset value
  localparam int         RELOC_SPACE_BIT = 0;
  localparam int         RELOC_BASE_LSB  = 1;
  localparam logic [7:0] RELOC_RST       = 8'h00;

  // Internal recovery time of a register access
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          REC_TIME_NS   = 100;
  localparam bwssp_wait_t REC_WAITS     =
    4'((REC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Implied A1..A0 from the byte enables of an 8-bit access
  function automatic logic [1:0] bwssp_a10(input logic [3:0] be_n);
    if (!be_n[0]) begin
      return 2'h0;
    end else if (!be_n[1]) begin
      return 2'h1;
    end else if (!be_n[2]) begin
      return 2'h2;
    end
    return 2'h3;
  endfunction : bwssp_a10

  // Write byte sits on D8..D15 for odd implied A0
  function automatic logic bwssp_lane_hi(input logic [3:0] be_n);
    return be_n[0] & (~be_n[1] | be_n[2]);
  endfunction : bwssp_lane_hi

  // Byte offset of an access inside the 256-byte window
  function automatic logic [7:0] bwssp_off(input bwssp_cyc_t c);
    return {c.addr[5:0], bwssp_a10(c.be_n)};
  endfunction : bwssp_off

endpackage : bwssp_pkg

//--- rtl/bwssp_bus_track.sv
`timescale 1ns/1ps
module bwssp_bus_track
  import bwssp_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // Observed bus status
  input  wire logic                  cycle_start_strobe_n,
  input  wire logic                  ready_in_n,
  input  wire bwssp_pkg::bwssp_cyc_t pins,
  // Data phase begins next cycle; in_data flags a data phase open now
  output logic                       start,
  output logic                       pipe,
  output bwssp_pkg::bwssp_cyc_t      attrs,
  output logic                       in_data
);

  bwssp_trk_t state_reg;
  bwssp_trk_t state_next;
  bwssp_cyc_t pend_reg;
  logic       ads;
  logic       rdy;

  assign ads = ~cycle_start_strobe_n;
  assign rdy = ~ready_in_n;

  // A strobe during an open data phase, before its ready, is a pipelined address
  assign start   = (state_reg == BWSSP_TRK_IDLE && ads) ||
                   (state_reg == BWSSP_TRK_BUSY && ads && rdy) ||
                   (state_reg == BWSSP_TRK_PEND && rdy);
  assign pipe    = (state_reg == BWSSP_TRK_PEND);
  assign attrs   = pipe ? pend_reg : pins;
  assign in_data = (state_reg != BWSSP_TRK_IDLE);

  // Next bus state, followed for every master at all times
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BWSSP_TRK_IDLE: begin
        if (ads) begin
          state_next = BWSSP_TRK_BUSY;
        end
      end
      BWSSP_TRK_BUSY: begin
        if (rdy && !ads) begin
          state_next = BWSSP_TRK_IDLE;
        end else if (!rdy && ads) begin
          state_next = BWSSP_TRK_PEND;
        end
      end
      BWSSP_TRK_PEND: begin
        if (rdy) begin
          state_next = BWSSP_TRK_BUSY;
        end
      end
      default: state_next = BWSSP_TRK_IDLE;
    endcase
  end

  // No select input feeds this, so deselection never upsets it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= BWSSP_TRK_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Hold attributes of a pipelined address until its data phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pend_reg <= '0;
    end else if (state_reg == BWSSP_TRK_BUSY && ads) begin
      pend_reg <= pins;
    end
  end

endmodule : bwssp_bus_track

//--- rtl/bwssp_top.sv
// Contract
// - Six 4-bit wait count registers: three memory, three I/O
// - Select code plus memory/I/O of the cycle picks the register
// - Each wait register holds 0 to 15, the wait states inserted
// - When selected, ready stays inactive for the programmed states
// - Select code 11 inserts no waits; peripheral makes its own ready
// - Bus state is tracked every cycle, whatever master or selection
// - Deselection never disturbs pipeline tracking
// - Pipelined cycle inserts exactly the register value
// - Non-pipelined cycle inserts the register value plus one
// - Reset loads every wait register with all ones
// - Pipelining judged from the address strobe and ready
// - Own register accesses get their recovery waits automatically
// - Slave writes take the byte from D0-D7 or D8-D15 only
// - Master mode moves data over the full 32-bit bus
// - After reset the window sits in I/O space at 0000H to 00DBH
// - Relocation moves window to even 256-byte I/O or 16-Mbyte memory
// - As master, cycles match processor cycles; pipelining recognised
// - Reset leaves the device in slave mode
// - Slave reads copy the byte onto all four byte lanes
`timescale 1ns/1ps
module bwssp_top
  import bwssp_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // Bus cycle status from the current master
  input  wire logic                   cycle_start_strobe_n,
  input  wire logic                   mem_io,
  input  wire logic                   wr_rd,
  input  wire bwssp_pkg::bwssp_addr_t addr,
  input  wire logic [3:0]             be_n,
  // Ready pin, shared open-drain style
  input  wire logic                   ready_in_n,
  output logic                        ready_out_n,
  output logic                        ready_oe,
  // Data pins
  input  wire logic [31:0]            data_in,
  output logic [31:0]                 data_out,
  output logic                        data_oe,
  // Wait select code from the accessed peripheral
  input  wire logic [1:0]             wait_sel,
  // Mastership
  input  wire logic                   hold_ack,
  input  wire logic [31:0]            master_wdata,
  output logic [31:0]                 master_rdata,
  output logic                        slave_mode
);

  // Tracker results
  bwssp_cyc_t  pins;
  bwssp_cyc_t  attrs;
  logic        start;
  logic        pipe;
  logic        in_data;
  logic        end_cyc;

  // Programmed state
  bwssp_wait_t wait_reg [NUM_WAIT];
  logic [7:0]  reloc_reg;

  // Current cycle and wait generator
  bwssp_cyc_t  cur_reg;
  logic        own_reg;
  logic        master_reg;
  logic        active_reg;
  logic        rdy_n_reg;
  logic [4:0]  cnt_reg;
  logic [31:0] dout_reg;
  logic        doe_reg;
  logic [31:0] mrd_reg;
  logic        slave_reg;

  // Decode of the cycle about to enter its data phase
  logic [7:0]  st_off;
  logic        reloc_mem;
  logic [6:0]  reloc_base;
  logic        io_hit;
  logic        mem_hit;
  logic        own_hit;
  logic        sel_on;
  logic [2:0]  sel_idx;
  bwssp_wait_t base_cnt;
  bwssp_wait_t sel_cnt;
  logic [4:0]  load_cnt;
  logic        drive;
  logic [7:0]  rd_byte;
  logic        rd_is_wait;
  logic [2:0]  rd_slot;

  // Decode of the cycle now ending
  logic [7:0]  wr_off;
  logic        wr_is_wait;
  logic [2:0]  wr_slot;
  logic [7:0]  wr_byte;
  logic        reg_we;

  // Offset decode shared by the read path and the write path
  function automatic logic bwssp_is_wait(input logic [7:0] off);
    return off >= OFF_WAIT0 && off < OFF_WAIT0 + 8'(NUM_WAIT);
  endfunction : bwssp_is_wait

  // Slot number; only meaningful where the offset hits a wait register
  function automatic logic [2:0] bwssp_slot(input logic [7:0] off);
    return 3'(off - OFF_WAIT0);
  endfunction : bwssp_slot

  // Status pins gathered into one cycle record
  assign pins = '{mem: mem_io, wr: wr_rd, addr: addr, be_n: be_n};

  // Bus state tracker; it sees every strobe, selected or not
  bwssp_bus_track u_track (
    .sys_clk              (sys_clk),
    .rst_n                (rst_n),
    .cycle_start_strobe_n (cycle_start_strobe_n),
    .ready_in_n           (ready_in_n),
    .pins                 (pins),
    .start                (start),
    .pipe                 (pipe),
    .attrs                (attrs),
    .in_data              (in_data)
  );

  // Any ready seen in a data phase ends that cycle, whoever drove it
  // Our own drive gives way at once when another source ends it first
  assign end_cyc = in_data & ~ready_in_n;

  // Window decode; base bits 15..9 or 31..25 keep boundaries even
  assign st_off     = bwssp_off(attrs);
  assign reloc_mem  = reloc_reg[RELOC_SPACE_BIT];
  assign reloc_base = reloc_reg[7:RELOC_BASE_LSB];
  assign io_hit     = !attrs.mem && !reloc_mem &&
                      attrs.addr[29:14] == '0 &&
                      attrs.addr[13:7] == reloc_base &&
                      !attrs.addr[6] && st_off <= OFF_LIMIT;
  assign mem_hit    = attrs.mem && reloc_mem &&
                      attrs.addr[29:23] == reloc_base &&
                      attrs.addr[22:6] == '0 &&
                      st_off <= OFF_LIMIT;
  assign own_hit    = !hold_ack && (io_hit || mem_hit);

  // Register choice: memory set above the I/O set
  assign sel_on   = (wait_sel != SEL_NONE);
  assign sel_idx  = attrs.mem ? 3'(wait_sel) + 3'(NUM_SEL)
                              : 3'(wait_sel);
  // Code 11 has no register of its own; the index is parked at slot 0
  // so no unknown reaches the counter on deselected cycles
  assign sel_cnt  = wait_reg[sel_on ? sel_idx : 3'h0];
  assign base_cnt = own_hit ? REC_WAITS : sel_cnt;

  // A strobe seen on an idle bus starts a non-pipelined cycle, which
  // needs one extra state before ready
  assign load_cnt = {1'b0, base_cnt} + {4'h0, ~pipe};
  assign drive    = own_hit || sel_on;

  // Read data of the addressed own register
  assign rd_is_wait = bwssp_is_wait(st_off);
  assign rd_slot    = bwssp_slot(st_off);
  assign rd_byte    = rd_is_wait ? {4'h0, wait_reg[rd_slot]} :
                      (st_off == OFF_RELOC) ? reloc_reg : 8'h00;

  // Write decode; the host copies the byte to both halves, so D16-D31
  // are never looked at
  assign wr_off     = bwssp_off(cur_reg);
  assign wr_is_wait = bwssp_is_wait(wr_off);
  assign wr_slot    = bwssp_slot(wr_off);
  assign wr_byte    = bwssp_lane_hi(cur_reg.be_n) ? data_in[15:8]
                                                  : data_in[7:0];
  assign reg_we     = end_cyc && own_reg && cur_reg.wr;

  // Wait registers; only four bits exist, so 0..15 is the full range
  // The upper nibble of a written byte is dropped
  for (genvar i = 0; i < NUM_WAIT; i++) begin : g_wait
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        wait_reg[i] <= WAIT_RST;
      end else if (reg_we && wr_is_wait && wr_slot == 3'(i)) begin
        wait_reg[i] <= wr_byte[3:0];
      end
    end
  end

  // Relocation register; reset places the window at I/O port 0
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reloc_reg <= RELOC_RST;
    end else if (reg_we && wr_off == OFF_RELOC) begin
      reloc_reg <= wr_byte;
    end
  end

  // Latch the cycle that enters its data phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur_reg <= '0;
    end else if (start) begin
      cur_reg <= attrs;
    end
  end

  // Ownership flags of that cycle, fixed for its whole data phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      own_reg    <= 1'b0;
      master_reg <= 1'b0;
    end else if (start) begin
      own_reg    <= own_hit;
      master_reg <= hold_ack;
    end
  end

  // Ownership of the ready wire; a new start outranks the old ending
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      active_reg <= 1'b0;
    end else if (start) begin
      active_reg <= drive;
    end else if (end_cyc) begin
      active_reg <= 1'b0;
    end
  end

  // Wait counter; runs down once per bus state while ready is owned
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (start) begin
      cnt_reg <= load_cnt;
    end else if (!end_cyc && active_reg && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 5'h1;
    end
  end

  // Ready drive, kept active low in the flop so the pin needs no gate
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdy_n_reg <= 1'b1;
    end else if (start) begin
      rdy_n_reg <= !(drive && load_cnt == '0);
    end else if (end_cyc) begin
      rdy_n_reg <= 1'b1;
    end else if (active_reg && cnt_reg != '0) begin
      rdy_n_reg <= cnt_reg != 5'h1;
    end
  end

  // Data enable: slave reads of own registers and master writes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      doe_reg <= 1'b0;
    end else if (start) begin
      doe_reg <= (own_hit && !attrs.wr) || (hold_ack && attrs.wr);
    end else if (end_cyc) begin
      doe_reg <= 1'b0;
    end
  end

  // Data word: byte copies on slave reads, full word as master
  // The word is only seen on the bus while data_oe is high
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dout_reg <= '0;
    end else if (start) begin
      dout_reg <= hold_ack ? master_wdata
                           : {4{rd_byte}};
    end
  end

  // Master reads take all 32 data bits when the cycle ends
  // Any source may end it; the word is taken on that same edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mrd_reg <= '0;
    end else if (end_cyc && master_reg && !cur_reg.wr) begin
      mrd_reg <= data_in;
    end
  end

  // Slave whenever the bus is not granted; slave after reset
  // The mode flag lags the grant by one state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      slave_reg <= 1'b1;
    end else begin
      slave_reg <= !hold_ack;
    end
  end

  // Ready pin; both drivers are flops, so no glitch reaches the wire
  assign ready_out_n  = rdy_n_reg;
  assign ready_oe     = active_reg;

  // Data pins
  assign data_out     = dout_reg;
  assign data_oe      = doe_reg;

  // Master capture and mode
  assign master_rdata = mrd_reg;
  assign slave_mode   = slave_reg;

endmodule : bwssp_top

//--- dv/bwssp_chk_sva.sv
`timescale 1ns/1ps
// Port checks of the ready generator, the mode flag and the slave and master data paths
module bwssp_chk (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Bus status and outputs
  input wire logic        cycle_start_strobe_n,
  input wire logic        ready_in_n,
  input wire logic        ready_out_n,
  input wire logic        ready_oe,
  input wire logic [31:0] data_out,
  input wire logic        data_oe,
  input wire logic        hold_ack,
  input wire logic [31:0] master_wdata,
  input wire logic        slave_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Reset state must already show at the first edge after release
  rst_state_a: assert property (disable iff (1'b0)
    !rst_n |=> slave_mode && !ready_oe && !data_oe && ready_out_n)
    else $error("outputs not idle during reset");
  mode_follow_a: assert property (
    $past(rst_n) |-> slave_mode == !$past(hold_ack))
    else $error("slave mode does not follow grant");
  drive_owned_a: assert property (
    !ready_out_n |-> ready_oe) else $error("ready low while not owned");
  // A data phase opens only after a strobe or an ending state
  phase_start_a: assert property (
    $rose(ready_oe) |-> $past(!cycle_start_strobe_n) || $past(!ready_in_n))
    else $error("data phase without cause");
  oe_hold_a: assert property (
    ready_oe && ready_out_n && ready_in_n |=> ready_oe)
    else $error("ready released before the ending state");
  wait_bound_a: assert property (
    $rose(ready_oe) |-> ##[0:16] !ready_in_n)
    else $error("more than sixteen wait states");
  lanes_copy_a: assert property (
    data_oe && slave_mode |-> data_out == {4{data_out[7:0]}})
    else $error("read byte not on all lanes");
  master_word_a: assert property (
    data_oe && !slave_mode |-> data_out == master_wdata)
    else $error("master write word wrong");
endmodule : bwssp_chk

//--- dv/bwssp_far_model.sv
`timescale 1ns/1ps
// Self-timed peripheral on the far side plus the shared ready wire
module bwssp_far_model #(
  parameter int DLY = 4
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Bus as the peripheral sees it
  input  wire logic       cycle_start_strobe_n,
  input  wire logic [1:0] wait_sel,
  // Ready wire drivers
  input  wire logic       ready_out_n,
  input  wire logic       ready_oe,
  output logic            ready_in_n
);
  int cnt;

  // Arms only on a deselecting strobe, so it never fights the generator
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt <= 0;
    end else if (!cycle_start_strobe_n && wait_sel == 2'h3 && cnt == 0) begin
      cnt <= DLY;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end

  // Pulled-up wire: low when any owner drives it low
  assign ready_in_n = !((ready_oe && !ready_out_n) || cnt == 1);
endmodule : bwssp_far_model

//--- dv/bwssp_tb_top.sv
`timescale 1ns/1ps
module bwssp_tb_top;
  import bwssp_pkg::*;
  localparam int FAR_DLY = 4;
  logic        sys_clk, rst_n, cycle_start_strobe_n, mem_io, wr_rd;
  logic        ready_in_n, ready_out_n, ready_oe, data_oe, hold_ack;
  logic        slave_mode, oe_seen, doe, msp;
  logic [1:0]  wait_sel;
  logic [3:0]  be_n;
  logic [31:0] data_in, data_out, master_wdata, master_rdata, dseen;
  bwssp_addr_t addr, base;
  bwssp_wait_t vals [6];
  int          err_total, checks_done, cycles, n;

  bwssp_top DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .cycle_start_strobe_n(cycle_start_strobe_n), .mem_io(mem_io),
    .wr_rd(wr_rd), .addr(addr), .be_n(be_n), .ready_in_n(ready_in_n),
    .ready_out_n(ready_out_n), .ready_oe(ready_oe), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .wait_sel(wait_sel),
    .hold_ack(hold_ack), .master_wdata(master_wdata),
    .master_rdata(master_rdata), .slave_mode(slave_mode));
  bwssp_far_model #(.DLY(FAR_DLY)) u_far (.sys_clk(sys_clk), .rst_n(rst_n),
    .cycle_start_strobe_n(cycle_start_strobe_n), .wait_sel(wait_sel),
    .ready_out_n(ready_out_n), .ready_oe(ready_oe), .ready_in_n(ready_in_n));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // One strobe state; the byte sits on its lane, its inverse on the other
  task automatic go(input logic m, w, input bwssp_addr_t a,
                    input logic [1:0] a10, sel, input logic [7:0] wb);
    @(posedge sys_clk);
    cycle_start_strobe_n <= 1'b0;
    mem_io <= m;
    wr_rd <= w;
    addr <= a;
    be_n <= ~(4'h1 << a10);
    wait_sel <= sel;
    data_in <= a10[0] ? {16'h5ac3, wb, ~wb} : {16'h5ac3, ~wb, wb};
    @(posedge sys_clk);
    cycle_start_strobe_n <= 1'b1;
  endtask : go

  // Counts states up to the ending one, bounded against a hang
  task automatic wait_rdy(output int k);
    k = 0;
    oe_seen = 1'b0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
      oe_seen |= ready_oe;
    end while (ready_in_n !== 1'b0 && k < 40);
    dseen = data_out;
    doe = data_oe;
  endtask : wait_rdy

  task automatic reg_io(input logic w, input logic [7:0] off, wb,
                        input bwssp_wait_t ev);
    int          k;
    logic [15:0] nib;
    go(msp, w, base | bwssp_addr_t'(off[7:2]), off[1:0], 2'h0, wb);
    wait_rdy(k);
    nib = {dseen[27:24], dseen[19:16], dseen[11:8], dseen[3:0]};
    chk("rec_waits", k, 32'(REC_WAITS) + 1);
    if (!w) begin
      chk("rd_oe", doe, 1);
      chk("rd_val", nib, {4{ev}});
    end
  endtask : reg_io

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    {rst_n, mem_io, wr_rd, hold_ack, msp} = '0;
    cycle_start_strobe_n = 1'b1;
    addr = '0;
    base = '0;
    be_n = 4'hf;
    data_in = '0;
    wait_sel = 2'h3;
    master_wdata = 32'h1234_5678;
    vals = '{4'h3, 4'h7, 4'h1, 4'h9, 4'h0, 4'he};
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("slave_mode", slave_mode, 1);
    for (int i = 0; i < 6; i++) begin
      reg_io(0, OFF_WAIT0 + 8'(i), 0, WAIT_RST);
    end
    go(0, 0, 30'h100, 0, 2'h1, 0);
    wait_rdy(n);
    chk("rst_waits", n, 32'(WAIT_RST) + 1);
    for (int i = 0; i < 6; i++) begin
      reg_io(1, OFF_WAIT0 + 8'(i), {4'ha, vals[i]}, 0);
    end
    for (int i = 0; i < 6; i++) begin
      reg_io(0, OFF_WAIT0 + 8'(i), 0, vals[i]);
    end
    for (int i = 0; i < 6; i++) begin
      go(i >= 3, 0, 30'h100, 0, 2'(i % 3), 0);
      wait_rdy(n);
      chk("sel_waits", n, 32'(vals[i]) + 1);
    end
    go(0, 0, 30'h100, 0, 2'h3, 0);
    wait_rdy(n);
    chk("self_rdy", n, FAR_DLY - 1);
    chk("self_oe", oe_seen, 0);
    // Deselected cycle with a pipelined access behind it
    go(0, 0, 30'h100, 0, 2'h3, 0);
    go(1, 0, 30'h100, 0, 2'h1, 0);
    wait_rdy(n);
    chk("first_end", n, 1);
    wait_rdy(n);
    chk("pipe_waits", n, 32'(vals[4]) + 1);
    @(posedge sys_clk);
    hold_ack <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("master_mode", slave_mode, 0);
    go(0, 1, 30'h1c, 2'h2, 2'h0, 0);
    wait_rdy(n);
    chk("mst_waits", n, 32'(vals[0]) + 1);
    chk("mst_word", dseen, master_wdata);
    // Master read: the whole word is taken at the ending state
    go(0, 0, 30'h1c, 2'h2, 2'h0, 8'h96);
    wait_rdy(n);
    chk("mst_rd_waits", n, 32'(vals[0]) + 1);
    @(posedge sys_clk);
    hold_ack <= 1'b0;
    #1;
    chk("mst_rdata", master_rdata, 32'h5ac3_6996);
    repeat (2) @(posedge sys_clk);
    reg_io(1, OFF_RELOC, 8'h03, 0);
    base = 30'h0080_0000;
    msp = 1'b1;
    reg_io(0, OFF_WAIT0, 0, vals[0]);
    go(0, 0, 30'h1c, 2'h2, 2'h3, 0);
    wait_rdy(n);
    chk("old_window", oe_seen, 0);
    // Reset in mid-run restores the counts and the default window
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    base = '0;
    msp = 1'b0;
    reg_io(0, OFF_WAIT0 + 8'h4, 0, WAIT_RST);
    tally_and_finish();
  end
endmodule : bwssp_tb_top

bind bwssp_top bwssp_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .cycle_start_strobe_n(cycle_start_strobe_n), .ready_in_n(ready_in_n),
  .ready_out_n(ready_out_n), .ready_oe(ready_oe), .data_out(data_out),
  .data_oe(data_oe), .hold_ack(hold_ack), .master_wdata(master_wdata),
  .slave_mode(slave_mode));
